//--- common/ifpf_pkg.sv
// Package of constants and types for the packet prologue framer
package ifpf_pkg;

  // ------------------------------------------------------------
  // Prologue layout
  // ------------------------------------------------------------
  localparam int PROLOGUE_WORDS = 7;
  localparam logic [3:0] TYPE_DATA_SID = 4'h1;
  localparam logic [3:0] TYPE_CONTEXT = 4'h4;
  localparam logic [3:0] TYPE_COMMAND = 4'h6;
  localparam int HDR_TYPE_LSB = 28;
  localparam int HDR_CLASS_BIT = 27;
  localparam int HDR_TSI_LSB = 22;
  localparam int HDR_TSF_LSB = 20;
  localparam int HDR_SEQ_LSB = 16;
  localparam logic [1:0] TSI_NONE = 2'h0;
  localparam logic [1:0] TSI_UTC = 2'h1;
  localparam logic [1:0] TSF_NONE = 2'h0;
  localparam logic [1:0] TSF_SAMPLES = 2'h1;
  localparam logic [1:0] TSF_PICO = 2'h2;
  localparam logic [1:0] TSF_FREE = 2'h3;
  // Arbitrary neutral organization identifier value
  localparam logic [23:0] ORG_ID_DEFAULT = 24'h00A5C3;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TAG = 8'h04;
  localparam logic [7:0] ADDR_CLASS = 8'h08;
  localparam logic [7:0] ADDR_RATE = 8'h0C;
  localparam logic [7:0] ADDR_PAYLEN = 8'h10;
  localparam logic [7:0] ADDR_SECS = 8'h14;
  localparam logic [7:0] ADDR_FRAC_LO = 8'h18;
  localparam logic [7:0] ADDR_FRAC_HI = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_MASK = 8'h24;
  localparam logic [7:0] ADDR_RX_HDR = 8'h28;
  localparam logic [7:0] ADDR_SEQ = 8'h2C;
  // Control fields
  localparam int CTRL_TSI_LSB = 0;
  localparam int CTRL_PAD_LSB = 8;
  localparam int CTRL_INFO_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] RATE_RESET = 32'h0000_03E8;
  localparam logic [15:0] PAYLEN_RESET = 16'h0001;
  // Status bits
  localparam int ST_TX_DONE = 0;
  localparam int ST_RX_DONE = 1;
  localparam int ST_RX_ERR = 2;
  localparam int ST_SECOND = 3;
  localparam int ST_BITS = 4;

  typedef enum logic [1:0] {
    IFPF_TX_IDLE, IFPF_TX_PRO, IFPF_TX_PAY
  } ifpf_tx_state_type;

endpackage : ifpf_pkg

//--- verilog/ifpf_framer.sv
// Packet prologue builder, checker and register slave
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
module ifpf_framer #(
  parameter logic [23:0] ORG_ID = ifpf_pkg::ORG_ID_DEFAULT,
  parameter logic [31:0] PICO_STEP = 32'd100000
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sample_tick,
  input wire logic tx_start,
  input wire logic [1:0] tx_kind,
  input wire logic [31:0] pay_data,
  input wire logic pay_valid,
  output logic pay_ready,
  output logic [31:0] tx_data,
  output logic tx_valid,
  output logic tx_first,
  output logic tx_last,
  input wire logic tx_ready,
  output logic tx_busy,
  input wire logic [31:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_first,
  output logic irq
);
  import ifpf_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] tag;
    logic [31:0] pkt_class;
    logic [31:0] rate;
    logic [15:0] paylen;
    logic [31:0] secs;
    logic [63:0] frac;
    logic [ST_BITS-1:0] status;
    logic [ST_BITS-1:0] mask;
    logic [31:0] rx_hdr;
    logic [11:0] seq;
    ifpf_tx_state_type tx_st;
    logic [1:0] kind;
    logic [2:0] widx;
    logic [15:0] pcnt;
    logic [31:0] tdata;
    logic tvalid;
    logic tfirst;
    logic tlast;
    logic [2:0] ridx;
    logic rerr;
    logic dph;
    logic dwr;
    logic [7:0] daddr;
    logic [31:0] rdata;
    logic irq;
  } ifpf_state_type;

  ifpf_state_type s_reg;
  ifpf_state_type s_next;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Fractional kind chosen from the packet class
  function automatic logic [1:0] frac_kind(input logic [15:0] cls);
    if (cls == 16'h0002 || cls == 16'h0003 || cls == 16'h0005) begin
      return TSF_SAMPLES;
    end
    return TSF_PICO;
  endfunction

  // Packet type code for a stream index
  function automatic logic [3:0] type_code(input logic [1:0] k);
    unique case (k)
      2'd1: return TYPE_CONTEXT;
      2'd2: return TYPE_COMMAND;
      default: return TYPE_DATA_SID;
    endcase
  endfunction

  // Class word for a stream: information class high, packet class low
  function automatic logic [31:0] class_word(input logic [31:0] c,
                                              input logic [15:0] info);
    return {info, c[15:0]};
  endfunction

  logic [1:0] cur_tsf;
  logic [31:0] hdr_word;
  logic [31:0] pro_word;
  logic [15:0] tot_size;
  logic wr_go;
  logic rd_go;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    cur_tsf = frac_kind(s_reg.pkt_class[15:0]);
    tot_size = s_reg.paylen + 16'(PROLOGUE_WORDS);
    hdr_word = {type_code(s_reg.kind), 1'b1, 3'b000,
                s_reg.ctrl[CTRL_TSI_LSB +: 2], cur_tsf,
                s_reg.seq[s_reg.kind*4 +: 4], tot_size};
    // Prologue words in fixed order
    unique case (s_reg.widx)
      3'd0: pro_word = hdr_word;
      3'd1: pro_word = s_reg.tag;
      3'd2: pro_word = {s_reg.ctrl[CTRL_PAD_LSB +: 5], 3'b000,
                        ORG_ID};
      3'd3: pro_word = class_word(s_reg.pkt_class,
                                  s_reg.ctrl[CTRL_INFO_LSB +: 16]);
      3'd4: pro_word = s_reg.secs;
      3'd5: pro_word = s_reg.frac[63:32];
      default: pro_word = s_reg.frac[31:0];
    endcase
    wr_go = s_reg.dph && s_reg.dwr;
    rd_go = hsel && hready && htrans[1] && !hwrite;
    // Read clears status first so that events later in this cycle win
    if (rd_go && haddr[7:0] == ADDR_STATUS) begin
      s_next.status = '0;
    end

    // Time keeping
    if (cur_tsf == TSF_SAMPLES) begin
      if (sample_tick) begin
        if (s_reg.frac + 64'd1 >= {32'd0, s_reg.rate}) begin
          s_next.secs = s_reg.secs + 32'd1;
          s_next.frac = '0;
          s_next.status[ST_SECOND] = 1'b1;
        end else begin
          s_next.frac = s_reg.frac + 64'd1;
        end
      end
    end else if (s_reg.frac + {32'd0, PICO_STEP} >= 64'd1000000000000) begin
      s_next.secs = s_reg.secs + 32'd1;
      s_next.frac = '0;
      s_next.status[ST_SECOND] = 1'b1;
    end else begin
      s_next.frac = s_reg.frac + {32'd0, PICO_STEP};
    end

    // Transmit output stage
    if (s_reg.tvalid && tx_ready) begin
      s_next.tvalid = 1'b0;
    end
    unique case (s_reg.tx_st)
      IFPF_TX_IDLE: begin
        if (tx_start && tx_kind != 2'd3) begin
          s_next.kind = tx_kind;
          s_next.widx = '0;
          s_next.tx_st = IFPF_TX_PRO;
        end
      end
      IFPF_TX_PRO: begin
        if (!s_reg.tvalid || tx_ready) begin
          s_next.tdata = pro_word;
          s_next.tvalid = 1'b1;
          s_next.tfirst = (s_reg.widx == 3'd0);
          s_next.tlast = (s_reg.widx == 3'd6) && (s_reg.paylen == 16'd0);
          s_next.widx = s_reg.widx + 3'd1;
          if (s_reg.widx == 3'd6) begin
            s_next.pcnt = s_reg.paylen;
            s_next.tx_st = (s_reg.paylen == 16'd0) ? IFPF_TX_IDLE
                                                    : IFPF_TX_PAY;
            if (s_reg.paylen == 16'd0) begin
              s_next.seq[s_reg.kind*4 +: 4] =
                s_reg.seq[s_reg.kind*4 +: 4] + 4'd1;
              s_next.status[ST_TX_DONE] = 1'b1;
            end
          end
        end
      end
      IFPF_TX_PAY: begin
        if ((!s_reg.tvalid || tx_ready) && pay_valid) begin
          s_next.tdata = pay_data;
          s_next.tvalid = 1'b1;
          s_next.tfirst = 1'b0;
          s_next.tlast = (s_reg.pcnt == 16'd1);
          s_next.pcnt = s_reg.pcnt - 16'd1;
          if (s_reg.pcnt == 16'd1) begin
            s_next.seq[s_reg.kind*4 +: 4] =
              s_reg.seq[s_reg.kind*4 +: 4] + 4'd1;
            s_next.status[ST_TX_DONE] = 1'b1;
            s_next.tx_st = IFPF_TX_IDLE;
          end
        end
      end
    endcase

    // Receive prologue checker
    if (rx_valid) begin
      if (rx_first) begin
        s_next.rx_hdr = rx_data;
        s_next.ridx = 3'd1;
        s_next.rerr = rx_data[31]
          || !(rx_data[31:28] == TYPE_DATA_SID
               || rx_data[31:28] == TYPE_CONTEXT
               || rx_data[31:28] == TYPE_COMMAND)
          || !rx_data[HDR_CLASS_BIT]
          || rx_data[HDR_TSI_LSB +: 2] == TSI_NONE
          || rx_data[HDR_TSF_LSB +: 2] == TSF_NONE
          || rx_data[HDR_TSF_LSB +: 2] == TSF_FREE;
      end else if (s_reg.ridx != 3'd0) begin
        s_next.ridx = (s_reg.ridx == 3'd6) ? 3'd0 : s_reg.ridx + 3'd1;
        if (s_reg.ridx == 3'd2) begin
          if (rx_data[26:24] != 3'b000 || rx_data[23:0] != ORG_ID) begin
            s_next.rerr = 1'b1;
          end
        end
        if (s_reg.ridx == 3'd6) begin
          s_next.status[ST_RX_DONE] = 1'b1;
          if (s_reg.rerr) begin
            s_next.status[ST_RX_ERR] = 1'b1;
          end
        end
      end
    end

    // Bus slave: address phase capture
    s_next.dph = hsel && hready && htrans[1];
    s_next.dwr = hwrite;
    s_next.daddr = haddr[7:0];
    if (rd_go) begin
      unique case (haddr[7:0])
        ADDR_CTRL: s_next.rdata = s_reg.ctrl;
        ADDR_TAG: s_next.rdata = s_reg.tag;
        ADDR_CLASS: s_next.rdata = s_reg.pkt_class;
        ADDR_RATE: s_next.rdata = s_reg.rate;
        ADDR_PAYLEN: s_next.rdata = {16'd0, s_reg.paylen};
        ADDR_SECS: s_next.rdata = s_reg.secs;
        ADDR_FRAC_LO: s_next.rdata = s_reg.frac[31:0];
        ADDR_FRAC_HI: s_next.rdata = s_reg.frac[63:32];
        ADDR_STATUS: s_next.rdata = {28'd0, s_reg.status};
        ADDR_MASK: s_next.rdata = {28'd0, s_reg.mask};
        ADDR_RX_HDR: s_next.rdata = s_reg.rx_hdr;
        ADDR_SEQ: s_next.rdata = {20'd0, s_reg.seq};
        default: s_next.rdata = '0;
      endcase
    end

    // Bus slave: data phase writes
    if (wr_go) begin
      unique case (s_reg.daddr)
        ADDR_CTRL: begin
          s_next.ctrl = hwdata;
          if (hwdata[CTRL_TSI_LSB +: 2] == TSI_NONE) begin
            s_next.ctrl[CTRL_TSI_LSB +: 2] = s_reg.ctrl[1:0];
          end
        end
        ADDR_TAG: s_next.tag = hwdata;
        ADDR_CLASS: s_next.pkt_class = hwdata;
        ADDR_RATE: s_next.rate = hwdata;
        ADDR_PAYLEN: s_next.paylen = hwdata[15:0];
        ADDR_SECS: begin
          s_next.secs = hwdata;
          s_next.frac = '0;
        end
        ADDR_MASK: s_next.mask = hwdata[ST_BITS-1:0];
        default: ;
      endcase
    end

    s_next.irq = |(s_next.status & s_next.mask);
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RESET;
      s_reg.rate <= RATE_RESET;
      s_reg.paylen <= PAYLEN_RESET;
      s_reg.tx_st <= IFPF_TX_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign hrdata = s_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign tx_data = s_reg.tdata;
  assign tx_valid = s_reg.tvalid;
  assign tx_first = s_reg.tfirst;
  assign tx_last = s_reg.tlast;
  assign tx_busy = (s_reg.tx_st != IFPF_TX_IDLE);
  assign pay_ready = (s_reg.tx_st == IFPF_TX_PAY)
                     && (!s_reg.tvalid || tx_ready);
  assign irq = s_reg.irq;

endmodule // ifpf_framer

//--- sim/ifpf_framer_sva.sv
// Assertion checker for the prologue framer output stream
module ifpf_framer_sva #(
  parameter logic [23:0] ORG_ID = 24'h000000
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [31:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_first,
  input wire logic tx_last,
  input wire logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] wcnt_reg;
  logic [15:0] size_reg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Words accepted so far and size field of the current packet
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wcnt_reg <= 16'h0000;
      size_reg <= 16'h0000;
    end else if (tx_valid && tx_ready) begin
      wcnt_reg <= tx_first ? 16'h0001 : wcnt_reg + 16'h0001;
      if (tx_first) begin
        size_reg <= tx_data[15:0];
      end
    end
  end

  property p_type;
    tx_valid && tx_first |-> tx_data[31:28] inside {4'h1, 4'h4, 4'h6};
  endproperty
  a_type: assert property (p_type) else $error("bad type");
  property p_class;
    tx_valid && tx_first |-> tx_data[27];
  endproperty
  a_class: assert property (p_class) else $error("class flag");
  property p_tsi;
    tx_valid && tx_first |-> tx_data[23:22] != 2'h0;
  endproperty
  a_tsi: assert property (p_tsi) else $error("time source");
  property p_tsf;
    tx_valid && tx_first |-> tx_data[21:20] inside {2'h1, 2'h2};
  endproperty
  a_tsf: assert property (p_tsf) else $error("fraction kind");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
      && $stable(tx_first);
  endproperty
  a_hold: assert property (p_hold) else $error("word dropped");
  property p_resv;
    tx_valid && !tx_first && wcnt_reg == 16'h0002 |-> tx_data[26:24] == 3'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits");
  property p_org;
    tx_valid && !tx_first && wcnt_reg == 16'h0002 |-> tx_data[23:0] == ORG_ID;
  endproperty
  a_org: assert property (p_org) else $error("organization id");
  property p_size;
    tx_valid && tx_last && !tx_first |-> wcnt_reg + 16'h0001 == size_reg;
  endproperty
  a_size: assert property (p_size) else $error("size field");
endmodule // ifpf_framer_sva

bind ifpf_framer ifpf_framer_sva #(.ORG_ID(ORG_ID)) u_sva (
  .ref_clk(ref_clk), .reset(reset), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_first(tx_first), .tx_last(tx_last), .tx_ready(tx_ready));

//--- sim/ifpf_sink.sv
// Packet stream sink model that stalls and records words
module ifpf_sink (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [31:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_first,
  input wire logic tx_last,
  input wire logic stall,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] got [0:15];
  int n;
  int pkts;

  // Ready toggles while stalling; words stored from the header on
  always @(posedge ref_clk) begin
    if (reset) begin
      tx_ready <= 1'b0;
      n <= 0;
      pkts <= 0;
    end else begin
      tx_ready <= stall ? !tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        got[tx_first ? 0 : n] <= tx_data;
        n <= tx_first ? 1 : n + 1;
        if (tx_last) begin
          pkts <= pkts + 1;
        end
      end
    end
  end
endmodule // ifpf_sink

//--- sim/ifpf_framer_tb.sv
// Testbench for the packet prologue framer
module ifpf_framer_tb;
  import ifpf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, hready, hreadyout, hresp, irq, pay_ready, tx_ready, tx_busy;
  logic reset = 1'b1, hsel = 1'b1, hwrite = 1'b0, sample_tick = 1'b0;
  logic tx_start = 1'b0, pay_valid = 1'b1, rx_valid = 1'b0, rx_first = 1'b0;
  logic stall = 1'b1;
  logic tx_valid, tx_first, tx_last;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, pay_data = 32'h0;
  logic [31:0] rx_data = 32'h0, hrdata, tx_data, q;
  logic [1:0] htrans = 2'h0, tx_kind = 2'h0;
  logic [31:0] bad [5] = '{32'h8850_0007, 32'h1050_0007, 32'h1810_0007,
                           32'h1870_0007, 32'h1850_0007};
  int n_fail = 0;
  int comparisons = 0;
  assign hready = hreadyout;

  ifpf_framer DUT (.ref_clk(ref_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sample_tick(sample_tick),
    .tx_start(tx_start), .tx_kind(tx_kind), .pay_data(pay_data),
    .pay_valid(pay_valid), .pay_ready(pay_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_first(tx_first), .tx_last(tx_last),
    .tx_ready(tx_ready), .tx_busy(tx_busy), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_first(rx_first), .irq(irq));
  ifpf_sink sink (.ref_clk(ref_clk), .reset(reset), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_first(tx_first), .tx_last(tx_last),
    .stall(stall), .tx_ready(tx_ready));

  // Clock and payload counter
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (pay_valid && pay_ready) begin
      pay_data <= pay_data + 32'h1;
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      n_fail++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
    bus(1'b0, a, 32'h0);
    chk(s, e, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic tick;
    @(posedge ref_clk);
    sample_tick <= 1'b1;
    @(posedge ref_clk);
    sample_tick <= 1'b0;
  endtask
  task automatic send(input logic [1:0] k);
    int p;
    p = sink.pkts;
    @(posedge ref_clk);
    tx_kind <= k;
    tx_start <= 1'b1;
    @(posedge ref_clk);
    tx_start <= 1'b0;
    for (int i = 0; i < 300 && sink.pkts == p; i++) @(posedge ref_clk);
    chk("packet", p + 1, sink.pkts);
    @(posedge ref_clk);
    chk("busy", 32'h0, {31'h0, tx_busy});
  endtask
  task automatic pkt(input logic [3:0] t, input logic [1:0] si,
                     input logic [1:0] sf, input logic [3:0] sq,
                     input logic [15:0] cls);
    chk("header", {t, 1'b1, si, sf, sq, 16'h0009},
        {sink.got[0][31:27], sink.got[0][23:0]});
    chk("tag", 32'hC0DE_0042, sink.got[1]);
    chk("class0", {8'h28, ORG_ID_DEFAULT}, sink.got[2]);
    chk("class1", {16'h0002, cls}, sink.got[3]);
    chk("payload", sink.got[7] + 32'h1, sink.got[8]);
  endtask
  task automatic rx(input logic [31:0] h, input logic [23:0] o,
                    input logic [31:0] e);
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_first <= (i == 0);
      rx_data <= (i == 0) ? h : (i == 2) ? {8'h00, o} : 32'h0;
    end
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_first <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("irq", {31'h0, e[2]}, {31'h0, irq});
    rd(ADDR_STATUS, e, "status");
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    rd(ADDR_CTRL, 32'h0000_0001, "ctrl reset");
    rd(ADDR_TAG, 32'h0, "tag reset");
    rd(8'h3C, 32'h0, "unmapped");
    tdone("reset");
    bus(1'b1, ADDR_TAG, 32'hC0DE_0042);
    bus(1'b1, ADDR_CLASS, 32'h0000_0002);
    bus(1'b1, ADDR_CTRL, 32'h0002_0501);
    bus(1'b1, ADDR_PAYLEN, 32'h0000_0002);
    bus(1'b1, ADDR_SECS, 32'h0000_0007);
    send(2'h0);
    pkt(4'h1, 2'h1, 2'h1, 4'h0, 16'h0002);
    chk("secs", 32'h7, sink.got[4]);
    chk("fraction", 32'h0, sink.got[5] | sink.got[6]);
    send(2'h0);
    pkt(4'h1, 2'h1, 2'h1, 4'h1, 16'h0002);
    send(2'h1);
    pkt(4'h4, 2'h1, 2'h1, 4'h0, 16'h0002);
    tdone("data and context");
    bus(1'b1, ADDR_CTRL, 32'h0002_0502);
    bus(1'b1, ADDR_CLASS, 32'h0000_0000);
    send(2'h2);
    pkt(4'h6, 2'h2, 2'h2, 4'h0, 16'h0000);
    bus(1'b1, ADDR_CTRL, 32'h0002_0500);
    rd(ADDR_CTRL, 32'h0002_0502, "ctrl source kept");
    rd(ADDR_STATUS, 32'h0000_0001, "tx done");
    tdone("command");
    bus(1'b1, ADDR_MASK, 32'h0000_0004);
    rx(32'h1850_0007, ORG_ID_DEFAULT, 32'h2);
    for (int i = 0; i < 5; i++) begin
      rx(bad[i], (i == 4) ? 24'h0 : ORG_ID_DEFAULT, 32'h6);
    end
    tdone("receive");
    bus(1'b1, ADDR_CLASS, 32'h0000_0002);
    bus(1'b1, ADDR_RATE, 32'h0000_0003);
    bus(1'b1, ADDR_SECS, 32'h0000_0005);
    tick();
    rd(ADDR_FRAC_LO, 32'h1, "fraction count");
    tick();
    tick();
    rd(ADDR_SECS, 32'h6, "seconds step");
    rd(ADDR_FRAC_LO, 32'h0, "fraction clear");
    tdone("sample count");
    finish_test();
  end

  // Watchdog against a hang
  initial begin
    #3_000_000;
    n_fail++;
    finish_test();
  end
endmodule // ifpf_framer_tb
